// >>> pkg/vga_gen_seq_pkg.sv
package vga_gen_seq_pkg;
	// i/o port addresses
	localparam logic [15:0] GOC_WR_ADDR   = 16'h03c2;
	localparam logic [15:0] STAT0_ADDR    = 16'h03c2;
	localparam logic [15:0] GOC_RD_ADDR   = 16'h03cc;
	localparam logic [15:0] FCR_RD_ADDR   = 16'h03ca;
	localparam logic [15:0] SEQ_IDX_ADDR  = 16'h03c4;
	localparam logic [15:0] SEQ_DAT_ADDR  = 16'h03c5;
	localparam logic [15:0] MONO_BASE     = 16'h03b0;
	localparam logic [15:0] COLOR_BASE    = 16'h03d0;
	localparam logic [15:0] STAT1_OFS     = 16'h000a;
	// sequencer indices
	localparam logic [3:0]  SEQ_RESET_IDX = 4'h0;
	localparam logic [3:0]  SEQ_CLOCK_IDX = 4'h1;
	// reset values
	localparam logic [7:0]  GOC_RESET     = 8'h00;
	localparam logic [7:0]  FCR_RESET     = 8'h00;
	localparam logic [7:0]  SEQ_RST_RESET = 8'h00;
	localparam logic [7:0]  SEQ_CLK_RESET = 8'h00;
	localparam logic [3:0]  SEQ_IDX_RESET = 4'h0;
	// general output control fields
	localparam int GOC_IO_SEL   = 0;
	localparam int GOC_VRAM_EN  = 1;
	localparam int GOC_CLK_LO   = 2;
	localparam int GOC_CLK_HI   = 3;
	localparam int GOC_PAGE     = 5;
	localparam int GOC_HPOL     = 6;
	localparam int GOC_VPOL     = 7;
	// pixel clock select codes
	localparam logic [1:0] PCLK_640 = 2'h0; // 25.175 MHz
	localparam logic [1:0] PCLK_720 = 2'h1; // 28.322 MHz
	// status and feature fields
	localparam int STAT0_IRQ    = 7;
	localparam int STAT0_MON    = 4;
	localparam int STAT1_DE     = 0;
	localparam int STAT1_VRS    = 3;
	localparam int STAT1_DIAG   = 4;
	localparam int FCR_VSC      = 3;
	localparam logic [7:0] FCR_MASK = 8'h08;
	// sequencer fields
	localparam int SR_ASYNC     = 0;
	localparam int SR_SYNC      = 1;
	localparam int CM_EIGHT     = 0;
	localparam int CM_HALF      = 2;
	localparam int CM_DOTHALF   = 3;
	localparam int CM_QUAD      = 4;
	localparam int CM_SCREENOFF = 5;
	localparam logic [7:0] SR_MASK  = 8'h03;
	localparam logic [7:0] CM_MASK  = 8'h3d;
	// character cell widths in dots
	localparam logic [3:0] CELL_NINE  = 4'h9;
	localparam logic [3:0] CELL_EIGHT = 4'h8;
endpackage : vga_gen_seq_pkg

// >>> rtl/vga_general_sequencer_regs.sv
module vga_general_sequencer_regs (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic        io_wr_in,
	input  wire logic        io_rd_in,
	input  wire logic [7:0]  io_wdata_in,
	output logic [7:0]       io_rdata_out,
	output logic             io_rvalid_out,
	input  wire logic        pixel_clock_input_in,
	input  wire logic        monitor_color_sense_in,
	input  wire logic        retrace_irq_pending_in,
	input  wire logic        hsync_raw_in,
	input  wire logic        vsync_raw_in,
	input  wire logic        hretrace_in,
	input  wire logic        vretrace_in,
	input  wire logic        vdisp_en_in,
	input  wire logic [7:0]  video_output_bits_in,
	input  wire logic [1:0]  color_plane_diag_sel_in,
	output logic             hsync_out,
	output logic             vsync_out,
	output logic             screen_blank_out,
	output logic             color_mode_out,
	output logic             host_vram_enable_out,
	output logic             page_select_odd_even_out,
	output logic [1:0]       pixel_clock_select_out,
	output logic             ext_clock_enable_out,
	output logic             sync_clear_n_out,
	output logic             async_halt_n_out,
	output logic             dot_clk_en_out,
	output logic             char_clk_en_out,
	output logic             serializer_load_out
);

	typedef struct packed {
		logic [7:0] goc;
		logic [7:0] feature_control;
		logic [3:0] idx;
		logic [7:0] seq_rst;
		logic [7:0] seq_clk;
		logic [7:0] rdata;
		logic       rvalid;
		logic [2:0] pix_sync;
		logic [1:0] mon_sync;
		logic       half_ph;
		logic [3:0] dot_cnt;
		logic [1:0] char_cnt;
	} state_s;

	state_s st_reg;
	state_s st_next;

	logic [15:0] base;
	logic        stat1_hit;
	logic        run;
	logic        pix_edge;
	logic        dot_en;
	logic [3:0]  dot_last;
	logic        char_en;
	logic        load_ok;
	logic [7:0]  stat0;
	logic [7:0]  stat1;
	logic [1:0]  diag;

	// address decode follows the i/o select bit
	assign base      = st_reg.goc[vga_gen_seq_pkg::GOC_IO_SEL] ?
		vga_gen_seq_pkg::COLOR_BASE : vga_gen_seq_pkg::MONO_BASE;
	assign stat1_hit = io_addr_in == (base + vga_gen_seq_pkg::STAT1_OFS);

	// status images
	always_comb begin
		unique case (color_plane_diag_sel_in)
			2'h0: diag = {video_output_bits_in[4], video_output_bits_in[0]};
			2'h1: diag = {video_output_bits_in[5], video_output_bits_in[1]};
			2'h2: diag = {video_output_bits_in[6], video_output_bits_in[2]};
			2'h3: diag = {video_output_bits_in[7], video_output_bits_in[3]};
		endcase
		stat0 = 8'h00;
		stat0[vga_gen_seq_pkg::STAT0_IRQ] = retrace_irq_pending_in;
		stat0[vga_gen_seq_pkg::STAT0_MON] = st_reg.mon_sync[1];
		stat1 = 8'h00;
		stat1[vga_gen_seq_pkg::STAT1_DIAG +: 2] = diag;
		stat1[vga_gen_seq_pkg::STAT1_VRS] = vretrace_in;
		stat1[vga_gen_seq_pkg::STAT1_DE] = hretrace_in | vretrace_in;
	end

	// dot, character and serializer timing
	assign run      = st_reg.seq_rst[vga_gen_seq_pkg::SR_SYNC] &
		st_reg.seq_rst[vga_gen_seq_pkg::SR_ASYNC];
	assign pix_edge = st_reg.pix_sync[1] & ~st_reg.pix_sync[2];
	assign dot_en   = run & pix_edge &
		(~st_reg.seq_clk[vga_gen_seq_pkg::CM_DOTHALF] | st_reg.half_ph);
	assign dot_last = st_reg.seq_clk[vga_gen_seq_pkg::CM_EIGHT] ?
		vga_gen_seq_pkg::CELL_EIGHT - 4'h1 : vga_gen_seq_pkg::CELL_NINE - 4'h1;
	assign char_en  = dot_en & (st_reg.dot_cnt == dot_last);
	always_comb begin
		if (st_reg.seq_clk[vga_gen_seq_pkg::CM_QUAD]) begin
			load_ok = st_reg.char_cnt == 2'h0;
		end else if (st_reg.seq_clk[vga_gen_seq_pkg::CM_HALF]) begin
			load_ok = ~st_reg.char_cnt[0];
		end else begin
			load_ok = 1'b1;
		end
	end

	// next state: register writes, read data, counters
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.pix_sync = {st_reg.pix_sync[1:0], pixel_clock_input_in};
		st_next.mon_sync = {st_reg.mon_sync[0], monitor_color_sense_in};
		if (io_wr_in) begin
			if (io_addr_in == vga_gen_seq_pkg::GOC_WR_ADDR) begin
				st_next.goc = io_wdata_in;
			end
			if (stat1_hit) begin
				st_next.feature_control = io_wdata_in & vga_gen_seq_pkg::FCR_MASK;
			end
			if (io_addr_in == vga_gen_seq_pkg::SEQ_IDX_ADDR) begin
				st_next.idx = io_wdata_in[3:0];
			end
			if (io_addr_in == vga_gen_seq_pkg::SEQ_DAT_ADDR) begin
				if (st_reg.idx == vga_gen_seq_pkg::SEQ_RESET_IDX) begin
					st_next.seq_rst = io_wdata_in & vga_gen_seq_pkg::SR_MASK;
				end
				if (st_reg.idx == vga_gen_seq_pkg::SEQ_CLOCK_IDX) begin
					st_next.seq_clk = io_wdata_in & vga_gen_seq_pkg::CM_MASK;
				end
			end
		end else if (io_rd_in) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = 8'h00;
			if (io_addr_in == vga_gen_seq_pkg::STAT0_ADDR) begin
				st_next.rdata = stat0;
			end else if (io_addr_in == vga_gen_seq_pkg::GOC_RD_ADDR) begin
				st_next.rdata = st_reg.goc;
			end else if (io_addr_in == vga_gen_seq_pkg::FCR_RD_ADDR) begin
				st_next.rdata = st_reg.feature_control;
			end else if (stat1_hit) begin
				st_next.rdata = stat1;
			end else if (io_addr_in == vga_gen_seq_pkg::SEQ_IDX_ADDR) begin
				st_next.rdata = {4'h0, st_reg.idx};
			end else if (io_addr_in == vga_gen_seq_pkg::SEQ_DAT_ADDR) begin
				if (st_reg.idx == vga_gen_seq_pkg::SEQ_RESET_IDX) begin
					st_next.rdata = st_reg.seq_rst;
				end else if (st_reg.idx == vga_gen_seq_pkg::SEQ_CLOCK_IDX) begin
					st_next.rdata = st_reg.seq_clk;
				end
			end else begin
				st_next.rvalid = 1'b0; // not our port
			end
		end
		if (!run) begin
			st_next.half_ph  = 1'b0;
			st_next.dot_cnt  = 4'h0;
			st_next.char_cnt = 2'h0;
		end else begin
			if (pix_edge) begin
				st_next.half_ph = ~st_reg.half_ph;
			end
			if (char_en) begin
				st_next.dot_cnt  = 4'h0;
				st_next.char_cnt = st_reg.char_cnt + 2'h1;
			end else if (dot_en) begin
				st_next.dot_cnt = st_reg.dot_cnt + 4'h1;
			end
		end
	end

	// single state register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= '{goc: vga_gen_seq_pkg::GOC_RESET, feature_control: vga_gen_seq_pkg::FCR_RESET,
				idx: vga_gen_seq_pkg::SEQ_IDX_RESET, seq_rst: vga_gen_seq_pkg::SEQ_RST_RESET,
				seq_clk: vga_gen_seq_pkg::SEQ_CLK_RESET, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign io_rdata_out             = st_reg.rdata;
	assign io_rvalid_out            = st_reg.rvalid;
	assign hsync_out                = hsync_raw_in ^ st_reg.goc[vga_gen_seq_pkg::GOC_HPOL];
	assign vsync_out                = (vsync_raw_in |
		(st_reg.feature_control[vga_gen_seq_pkg::FCR_VSC] & vdisp_en_in)) ^
		st_reg.goc[vga_gen_seq_pkg::GOC_VPOL];
	assign screen_blank_out         = st_reg.seq_clk[vga_gen_seq_pkg::CM_SCREENOFF];
	assign color_mode_out           = st_reg.goc[vga_gen_seq_pkg::GOC_IO_SEL];
	assign host_vram_enable_out     = st_reg.goc[vga_gen_seq_pkg::GOC_VRAM_EN];
	assign page_select_odd_even_out = st_reg.goc[vga_gen_seq_pkg::GOC_PAGE];
	assign pixel_clock_select_out   =
		st_reg.goc[vga_gen_seq_pkg::GOC_CLK_HI:vga_gen_seq_pkg::GOC_CLK_LO];
	assign ext_clock_enable_out     = st_reg.goc[vga_gen_seq_pkg::GOC_CLK_HI];
	assign sync_clear_n_out         = st_reg.seq_rst[vga_gen_seq_pkg::SR_SYNC];
	assign async_halt_n_out         = st_reg.seq_rst[vga_gen_seq_pkg::SR_ASYNC];
	// halt gates the enables at once, with no clock edge in between
	assign dot_clk_en_out           = dot_en & async_halt_n_out;
	assign char_clk_en_out          = char_en & async_halt_n_out;
	assign serializer_load_out      = char_en & load_ok & async_halt_n_out;

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	goc_write_a: assert property (io_wr_in && io_addr_in == 16'h03c2 |=>
		st_reg.goc == $past(io_wdata_in)) else $error("output control write lost");
	goc_readback_a: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h03cc
		|=> io_rvalid_out && io_rdata_out == $past(st_reg.goc))
		else $error("output control readback wrong");
	stat0_read_a: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h03c2
		|=> io_rdata_out[7] == $past(retrace_irq_pending_in) && io_rdata_out[3:0] == 4'h0)
		else $error("status zero wrong");
	mono_decode_a: assert property (io_rd_in && !io_wr_in && !color_mode_out &&
		io_addr_in == 16'h03da |=> !io_rvalid_out) else $error("colour port hit in mono");
	vsync_gate_a: assert property (st_reg.feature_control[3] && vdisp_en_in && !st_reg.goc[7]
		|-> vsync_out) else $error("vsync gate missing");
	// index reads back with the upper nibble zero
	seq_index_a: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h03c4 |=>
		io_rvalid_out && io_rdata_out == {4'h0, $past(st_reg.idx)})
		else $error("index readback wrong");
	sync_halt_a: assert property (!sync_clear_n_out |=> st_reg.dot_cnt == 4'h0 &&
		st_reg.char_cnt == 2'h0) else $error("sequencer not cleared");
	async_halt_a: assert property (!async_halt_n_out |-> !dot_clk_en_out &&
		!char_clk_en_out && !serializer_load_out) else $error("halt leaks enable");
	cell_width_a: assert property (char_clk_en_out |-> st_reg.dot_cnt ==
		(st_reg.seq_clk[0] ? 4'h7 : 4'h8)) else $error("cell width wrong");
	quad_load_a: assert property (serializer_load_out && st_reg.seq_clk[4] |->
		st_reg.char_cnt == 2'h0) else $error("quad load off");
	half_dot_a: assert property (dot_clk_en_out && st_reg.seq_clk[3] |->
		st_reg.half_ph) else $error("dot clock not halved");

	// feature control lands masked at the selected base
	fcr_write_a: assert property (io_wr_in &&
		io_addr_in == (color_mode_out ? 16'h03da : 16'h03ba) |=>
		st_reg.feature_control == ($past(io_wdata_in) & 8'h08)) else $error("feature write lost");
	// feature control reads back at its fixed port
	fcr_readback_a: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h03ca
		|=> io_rvalid_out && io_rdata_out == $past(st_reg.feature_control))
		else $error("feature readback wrong");
	// index register keeps the low nibble
	idx_write_a: assert property (io_wr_in && io_addr_in == 16'h03c4 |=>
		st_reg.idx == $past(io_wdata_in[3:0])) else $error("index write lost");
	// reset register written through the data port at index zero
	seq_rst_write_a: assert property (io_wr_in && io_addr_in == 16'h03c5 &&
		st_reg.idx == 4'h0 |=> st_reg.seq_rst == ($past(io_wdata_in) & 8'h03))
		else $error("reset register write lost");
	// clocking register written through the data port at index one
	seq_clk_write_a: assert property (io_wr_in && io_addr_in == 16'h03c5 &&
		st_reg.idx == 4'h1 |=> st_reg.seq_clk == ($past(io_wdata_in) & 8'h3d))
		else $error("clocking register write lost");
	// reset register read back through the data port
	seq_rst_read_a: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h03c5 &&
		st_reg.idx == 4'h0 |=> io_rvalid_out && io_rdata_out == $past(st_reg.seq_rst))
		else $error("reset register readback wrong");
	// clocking register read back through the data port
	seq_clk_read_a: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h03c5 &&
		st_reg.idx == 4'h1 |=> io_rvalid_out && io_rdata_out == $past(st_reg.seq_clk))
		else $error("clocking register readback wrong");
	// reserved bits are never stored
	reserved_bits_a: assert property (st_reg.feature_control[7:4] == 4'h0 && st_reg.feature_control[2:0] == 3'h0 &&
		st_reg.seq_rst[7:2] == 6'h00 && st_reg.seq_clk[7:6] == 2'h0 && !st_reg.seq_clk[1])
		else $error("reserved bit stored");
	// retrace summary bit of status one
	stat1_retrace_a: assert property (io_rd_in && !io_wr_in &&
		io_addr_in == (color_mode_out ? 16'h03da : 16'h03ba) |=> io_rvalid_out &&
		io_rdata_out[0] == $past(hretrace_in | vretrace_in))
		else $error("retrace bit wrong");
	// vertical retrace flag of status one
	stat1_vflag_a: assert property (io_rd_in && !io_wr_in &&
		io_addr_in == (color_mode_out ? 16'h03da : 16'h03ba) |=>
		io_rdata_out[3] == $past(vretrace_in)) else $error("vertical flag wrong");
	// diagnostic pair follows the plane select
	stat1_diag_a: assert property (io_rd_in && !io_wr_in &&
		io_addr_in == (color_mode_out ? 16'h03da : 16'h03ba) |=>
		io_rdata_out[5:4] == $past({video_output_bits_in[color_plane_diag_sel_in + 3'h4],
		video_output_bits_in[color_plane_diag_sel_in]})) else $error("diag pair wrong");
	// reserved positions of status one read zero
	stat1_zero_a: assert property (io_rd_in && !io_wr_in &&
		io_addr_in == (color_mode_out ? 16'h03da : 16'h03ba) |=> io_rdata_out[7:6] == 2'h0
		&& io_rdata_out[2:1] == 2'h0) else $error("status one reserved set");
	// monitor type bit of status zero
	mon_type_a: assert property (io_rd_in && !io_wr_in && io_addr_in == 16'h03c2 |=>
		io_rdata_out[4] == $past(st_reg.mon_sync[1]) && io_rdata_out[6:5] == 2'h0)
		else $error("monitor type wrong");
	// mono status port is dead in colour mode
	color_decode_a: assert property (io_rd_in && !io_wr_in && color_mode_out &&
		io_addr_in == 16'h03ba |=> !io_rvalid_out) else $error("mono port hit in colour");
	// horizontal sync polarity
	hsync_pos_a: assert property (!st_reg.goc[6] |-> hsync_out == hsync_raw_in)
		else $error("hsync not positive");
	hsync_neg_a: assert property (st_reg.goc[6] |-> hsync_out == !hsync_raw_in)
		else $error("hsync not negative");
	// vertical sync polarity while the gate is off
	vsync_plain_a: assert property (!st_reg.feature_control[3] && !st_reg.goc[7] |->
		vsync_out == vsync_raw_in) else $error("vsync not plain");
	vsync_neg_a: assert property (!st_reg.feature_control[3] && st_reg.goc[7] |->
		vsync_out == !vsync_raw_in) else $error("vsync not negative");
	// page select follows its bit
	page_sel_a: assert property (page_select_odd_even_out == st_reg.goc[5])
		else $error("page select wrong");
	// host memory access follows its bit
	vram_gate_a: assert property (host_vram_enable_out == st_reg.goc[1])
		else $error("host access gate wrong");
	// pixel clock choice and external source
	clock_sel_a: assert property (pixel_clock_select_out == st_reg.goc[3:2] &&
		ext_clock_enable_out == st_reg.goc[3]) else $error("clock select wrong");
	// blanking follows screen off
	screen_off_a: assert property (screen_blank_out == st_reg.seq_clk[5])
		else $error("blank wrong");
	// enables only while both reset bits are high
	run_gate_a: assert property (dot_clk_en_out |-> sync_clear_n_out && async_halt_n_out)
		else $error("dot enable while halted");
	// loads only land on character boundaries
	load_char_a: assert property (serializer_load_out |-> char_clk_en_out)
		else $error("load off boundary");
	// half-rate loads on even characters
	half_load_a: assert property (serializer_load_out && st_reg.seq_clk[2] &&
		!st_reg.seq_clk[4] |-> !st_reg.char_cnt[0]) else $error("half load off");
	// every character loads when neither rate bit is set
	full_load_a: assert property (char_clk_en_out && !st_reg.seq_clk[2] &&
		!st_reg.seq_clk[4] |-> serializer_load_out) else $error("load missed");
	// dot counter steps by one inside a cell
	dot_step_a: assert property (dot_clk_en_out && !char_clk_en_out |=>
		st_reg.dot_cnt == $past(st_reg.dot_cnt) + 4'h1) else $error("dot step wrong");
	// dot counter wraps at the end of a cell
	dot_wrap_a: assert property (char_clk_en_out |=> st_reg.dot_cnt == 4'h0)
		else $error("dot wrap wrong");
	// character counter steps once per cell
	char_step_a: assert property (char_clk_en_out |=>
		st_reg.char_cnt == $past(st_reg.char_cnt) + 2'h1) else $error("char step wrong");
	// output control changes only on its write
	goc_hold_a: assert property (!(io_wr_in && io_addr_in == 16'h03c2) |=>
		$stable(st_reg.goc)) else $error("output control drifted");
	// feature control changes only on its write
	fcr_hold_a: assert property (!(io_wr_in &&
		io_addr_in == (color_mode_out ? 16'h03da : 16'h03ba)) |=>
		$stable(st_reg.feature_control)) else $error("feature control drifted");
	// index changes only on its write
	idx_hold_a: assert property (!(io_wr_in && io_addr_in == 16'h03c4) |=>
		$stable(st_reg.idx)) else $error("index drifted");
	// read data holds between reads
	rdata_hold_a: assert property (!io_rd_in || io_wr_in |=>
		io_rdata_out == $past(io_rdata_out)) else $error("read data drifted");
	// read valid only answers a read
	rvalid_cause_a: assert property (io_rvalid_out |-> $past(io_rd_in) &&
		!$past(io_wr_in)) else $error("stray read valid");
	// colour mode output mirrors the i/o select bit
	base_sel_a: assert property (color_mode_out == st_reg.goc[0])
		else $error("base select wrong");

endmodule : vga_general_sequencer_regs

// >>> testbench/host_io_model.sv
// host processor side: single-byte i/o port cycles, one strobe per access
module host_io_model (
	input  wire logic        clk_in,
	input  wire logic        rvalid_in,
	input  wire logic [7:0]  rdata_in,
	output logic [15:0]      addr_out,
	output logic             wr_out,
	output logic             rd_out,
	output logic [7:0]       wdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// bus idle from time zero
	initial begin
		addr_out = 16'h0000;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// write strobe for one cycle; released lines show the inverse, not old values
	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask : io_write
	// read strobe for one cycle; answer looked for at the two following falling edges
	task automatic io_read(input logic [15:0] a, output logic v, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		v = rvalid_in;
		d = rdata_in;
		@(negedge clk_in);
		if (v !== 1'b1) begin
			v = rvalid_in;
			d = rdata_in;
		end
	endtask : io_read
endmodule : host_io_model

// >>> testbench/testbench.sv
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in = 1'b0, rst_n_in = 1'b0, wr, rd, rvalid, pclk = 1'b0;
	logic        mon = 1'b0, irq = 1'b0, hs = 1'b0, vs = 1'b0, hr = 1'b0, vr = 1'b0;
	logic        vde = 1'b0, hsync, vsync, blank, color, vram, page, ext, sclr, ahalt;
	logic        dclk, cclk, sload;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, vid = 8'h10;
	logic [1:0]  sel = 2'h0, pcsel;
	int          err_count = 0, cmp_count = 0;
	// clock and a free-running pixel clock pin
	always #2 clk_in = ~clk_in;
	always #5 pclk = ~pclk;
	host_io_model host (.clk_in(clk_in), .rvalid_in(rvalid), .rdata_in(rdata),
		.addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
	vga_general_sequencer_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(addr),
		.io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata), .io_rdata_out(rdata),
		.io_rvalid_out(rvalid), .pixel_clock_input_in(pclk), .monitor_color_sense_in(mon),
		.retrace_irq_pending_in(irq), .hsync_raw_in(hs), .vsync_raw_in(vs),
		.hretrace_in(hr), .vretrace_in(vr), .vdisp_en_in(vde), .video_output_bits_in(vid),
		.color_plane_diag_sel_in(sel), .hsync_out(hsync), .vsync_out(vsync),
		.screen_blank_out(blank), .color_mode_out(color), .host_vram_enable_out(vram),
		.page_select_odd_even_out(page), .pixel_clock_select_out(pcsel),
		.ext_clock_enable_out(ext), .sync_clear_n_out(sclr), .async_halt_n_out(ahalt),
		.dot_clk_en_out(dclk), .char_clk_en_out(cclk), .serializer_load_out(sload));
	// claimed read, data compared
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		logic       v;
		logic [7:0] d;
		host.io_read(a, v, d);
		`CHK(v, 1'b1)
		`CHK(d, e)
	endtask : rd_chk
	// unclaimed read gives no valid
	task automatic rd_none(input logic [15:0] a);
		logic       v;
		logic [7:0] d;
		host.io_read(a, v, d);
		`CHK(v, 1'b0)
	endtask : rd_none
	// reset values of every register except the clocking register
	task automatic reset_values;
		rd_chk(vga_gen_seq_pkg::GOC_RD_ADDR, 8'h00);
		rd_chk(vga_gen_seq_pkg::FCR_RD_ADDR, 8'h00);
		rd_chk(vga_gen_seq_pkg::SEQ_IDX_ADDR, 8'h00);
		rd_chk(vga_gen_seq_pkg::SEQ_DAT_ADDR, 8'h00);
	endtask : reset_values
	// output control fields, written as ed then 26, outputs checked after each
	task automatic output_fields;
		host.io_write(16'h03c2, 8'hed);
		rd_chk(16'h03cc, 8'hed);
		`CHK({color, vram, page, pcsel, ext}, 6'h2f)
		`CHK({hsync, vsync}, 2'h3)
		host.io_write(16'h03c2, 8'h26);
		`CHK({color, vram, page, pcsel, ext}, 6'h1a)
		`CHK({hsync, vsync}, 2'h0)
	endtask : output_fields
	// status zero follows interrupt and monitor sense
	task automatic status_zero;
		irq = 1'b1;
		mon = 1'b1;
		repeat (3) @(negedge clk_in);
		rd_chk(16'h03c2, 8'h90);
		irq = 1'b0;
		mon = 1'b0;
		repeat (3) @(negedge clk_in);
		rd_chk(16'h03c2, 8'h00);
	endtask : status_zero
	// base selection, feature control and status one
	task automatic base_and_status;
		rd_none(16'h03da);
		host.io_write(16'h03ba, 8'hff);
		rd_chk(16'h03ca, 8'h08);
		host.io_write(16'h03c2, 8'h01);
		rd_none(16'h03ba);
		vde = 1'b1;
		#1;
		`CHK(vsync, 1'b1)
		hr = 1'b1;
		rd_chk(16'h03da, 8'h21);
		hr = 1'b0;
		vr = 1'b1;
		sel = 2'h1;
		vid = 8'h02;
		rd_chk(16'h03da, 8'h19);
		host.io_write(16'h03da, 8'h00);
		`CHK(vsync, 1'b0)
	endtask : base_and_status
	// sequencer index and data registers
	task automatic sequencer_regs;
		host.io_write(16'h03c4, 8'h01);
		rd_chk(16'h03c4, 8'h01);
		host.io_write(16'h03c5, 8'hff);
		rd_chk(16'h03c5, 8'h3d);
		`CHK(blank, 1'b1)
		host.io_write(16'h03c4, 8'h00);
		host.io_write(16'h03c5, 8'hff);
		rd_chk(16'h03c5, 8'h03);
		`CHK({sclr, ahalt}, 2'h3)
		host.io_write(16'h03c5, 8'h02);
		`CHK({sclr, ahalt}, 2'h2)
	endtask : sequencer_regs
	// cell width and serializer load rate with the sequencer running
	task automatic cell_timing(input logic [7:0] cm, input int dots_exp, input int chars_exp);
		int dots;
		int chars;
		int loads;
		dots = 0;
		chars = 0;
		loads = 0;
		host.io_write(16'h03c4, 8'h00);
		host.io_write(16'h03c5, 8'h00);
		host.io_write(16'h03c4, 8'h01);
		host.io_write(16'h03c5, cm);
		host.io_write(16'h03c4, 8'h00);
		host.io_write(16'h03c5, 8'h03);
		for (int n = 0; n < 2000 && loads < 2; n++) begin
			if (dclk === 1'b1) begin
				dots++;
			end
			if (cclk === 1'b1) begin
				`CHK(dots, dots_exp)
				dots = 0;
				chars++;
			end
			if (sload === 1'b1) begin
				loads++;
				if (loads == 2) begin
					`CHK(chars, chars_exp)
				end
				chars = 0;
			end
			@(negedge clk_in);
		end
		`CHK(loads, 2)
	endtask : cell_timing
	// verdict and end of run
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// main sequence
	initial begin
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
		reset_values();
		output_fields();
		status_zero();
		base_and_status();
		sequencer_regs();
		cell_timing(8'h00, 9, 1);
		cell_timing(8'h05, 8, 2);
		cell_timing(8'h19, 8, 4);
		results();
	end
endmodule : testbench
